/* rtl/host_port_pkg.sv */
// Purpose: Shared constants and types for the host buffer port.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes:   Status and port-2 bit positions live here only.
package host_port_pkg;

  localparam int          DATA_W      = 8;
  localparam int          FETCH_W     = 11;
  localparam int          FETCH_LO_W  = 8;
  localparam int          FETCH_HI_W  = 3;
  localparam int          BUF_DEPTH   = 2;
  localparam int          USER_W      = 4;

  // Status register layout
  localparam int          ST_OBF      = 0;
  localparam int          ST_IBF      = 1;
  localparam int          ST_FLAG0    = 2;
  localparam int          ST_CMD      = 3;
  localparam int          ST_USER_LO  = 4;

  // Port 2 special pins
  localparam int          P2_OBF      = 4;
  localparam int          P2_IBF      = 5;
  localparam int          P2_DRQ      = 6;
  localparam int          P2_DMA_ACKNOWLEDGE_IN     = 7;
  localparam int          P2_ADDR_LO  = 0;

  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  OE_N_IDLE   = 8'hFF;
  localparam logic [10:0] FETCH_RST   = 11'h000;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_READ  = 2'b01,
    H_WRITE = 2'b10
  } host_state_t;

  typedef enum logic {
    S_RUN  = 1'b0,
    S_HALT = 1'b1
  } step_state_t;

endpackage : host_port_pkg

/* rtl/byte_stream_if.sv */
// Purpose: Valid/ready byte stream between the port logic and its buffer.
// Assumes: Transfer happens on a clock edge with valid and ready both high.
// Notes:   Source holds data and valid until ready.
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

/* rtl/two_entry_buffer.sv */
// Purpose: Small FIFO holding firmware bytes bound for the host.
// Assumes: Push and pop may happen in the same cycle.
// Notes:   Ready and valid come straight from flip-flops.
`timescale 1ns/1ns
module two_entry_buffer
  import host_port_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic   clk_i,
  input  wire logic   sys_rst_i,
  byte_stream_if.snk  push,
  byte_stream_if.src  pop
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic             room, next_room;
  logic             filled, next_filled;
  logic             do_push;
  logic             do_pop;

  assign push.ready = room;
  assign pop.valid  = filled;
  assign pop.data   = mem[rd_ptr];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
        next_mem[i] = (do_push && wr_ptr == PTR_W'(i)) ? push.data : mem[i];
      end
    end
  endgenerate

  always_comb begin
    do_push     = push.valid && room;
    do_pop      = filled && pop.ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_push) begin
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count  = count + CNT_W'(do_push) - CNT_W'(do_pop);
    next_room   = next_count != CNT_W'(DEPTH);
    next_filled = next_count != '0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      room   <= 1'b1;
      filled <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      room   <= next_room;
      filled <= next_filled;
    end
  end

  always_ff @(posedge clk_i) begin
    mem <= next_mem;
  end

endmodule : two_entry_buffer

/* rtl/step_sync_ctrl.sv */
// Purpose: Single-step halt control and per-instruction sync pulse.
// Assumes: Core pulses instr_boundary_i when an instruction completes.
// Notes:   Core may start the next instruction only while run_o is high.
`timescale 1ns/1ns
module step_sync_ctrl
  import host_port_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic single_step_n_i,
  input  wire logic instr_boundary_i,
  output logic      run_o,
  output logic      halted_o,
  output logic      sync_o
);

  step_state_t state, next_state;
  logic        next_run;
  logic        next_sync;

  always_comb begin
    next_state = state;
    next_sync  = 1'b0;
    unique case (state)
      S_RUN: begin
        if (instr_boundary_i && !single_step_n_i) begin
          next_state = S_HALT;
        end else if (instr_boundary_i) begin
          next_sync = 1'b1;
        end
      end
      S_HALT: begin
        // sync marks the stepped instruction start
        if (single_step_n_i) begin
          next_state = S_RUN;
          next_sync  = 1'b1;
        end
      end
    endcase
    next_run = next_state == S_RUN;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state    <= S_RUN;
      run_o    <= 1'b1;
      halted_o <= 1'b0;
      sync_o   <= 1'b0;
    end else begin
      state    <= next_state;
      run_o    <= next_run;
      halted_o <= !next_run;
      sync_o   <= next_sync;
    end
  end

endmodule : step_sync_ctrl

/* rtl/slave_mcu_host_buffer_port.sv */
// Purpose: Host-side slave port of a peripheral controller: input buffer,
//          two-deep output buffer, status byte, port-2 handshake pins,
//          single-step and sync support.
// Assumes: All pins are synchronous to clk_i; strobes and chip select active low.
// Notes:   Host strobes are registered, so bus drive follows by one cycle.
//          Output-full drops only after the host ends a data read strobe.
//          An acknowledge on port-2 bit 7 selects the data buffer like chip select.
`timescale 1ns/1ns
module slave_mcu_host_buffer_port
  import host_port_pkg::*;
(
  input  wire logic [7:0]  host_data_bus_i,
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        read_n_i,
  input  wire logic        write_n_i,
  input  wire logic        register_select_i,
  output logic      [7:0]  host_data_bus_o,
  output logic             host_data_bus_oe_n_o,
  input  wire logic [7:0]  fw_out_data_i,
  input  wire logic        fw_out_valid_i,
  output logic             fw_out_ready_o,
  output logic      [7:0]  fw_in_data_o,
  output logic             fw_in_command_o,
  output logic             fw_in_valid_o,
  input  wire logic        fw_in_ready_i,
  input  wire logic        fw_flag0_i,
  input  wire logic [3:0]  fw_status_user_i,
  input  wire logic        fw_dma_request_i,
  input  wire logic        port2_special_en_i,
  input  wire logic [7:0]  port1_latch_i,
  input  wire logic [7:0]  port1_drive_i,
  input  wire logic [7:0]  port2_latch_i,
  input  wire logic [7:0]  port2_drive_i,
  input  wire logic [7:0]  port2_i,
  output logic      [7:0]  port1_o,
  output logic      [7:0]  port1_oe_n_o,
  output logic      [7:0]  port2_o,
  output logic      [7:0]  port2_oe_n_o,
  output logic             dma_request_out_o,
  input  wire logic        single_step_n_i,
  input  wire logic        instr_boundary_i,
  input  wire logic [10:0] fetch_addr_i,
  output logic             cpu_run_o,
  output logic             sync_o
);

  byte_stream_if #(.WIDTH(DATA_W)) fw_to_buf ();
  byte_stream_if #(.WIDTH(DATA_W)) buf_to_host ();

  // Host bus side
  host_state_t      state;
  host_state_t      next_state;
  logic             read_sel;
  logic             next_read_sel;
  logic [7:0]       bus_out;
  logic [7:0]       next_bus_out;
  logic             bus_oe_n;
  logic             next_bus_oe_n;

  // Firmware side
  logic [7:0]       in_data;
  logic [7:0]       next_in_data;
  logic             in_cmd;
  logic             next_in_cmd;
  logic             in_buffer_full;
  logic             next_ibf;
  logic             dma_request_out;
  logic             next_drq;

  // Port pins
  logic [7:0]       p1_out;
  logic [7:0]       next_p1_out;
  logic [7:0]       p1_oe_n;
  logic [7:0]       next_p1_oe_n;
  logic [7:0]       p2_out;
  logic [7:0]       next_p2_out;
  logic [7:0]       p2_oe_n;
  logic [7:0]       next_p2_oe_n;

  logic             out_buffer_full;
  logic             halted;
  logic             dma_acknowledge_in_active;
  logic             selected;
  logic             eff_rs;
  logic             rd_act;
  logic             wr_act;
  logic             host_write;
  logic             data_read_done;
  logic             dma_acknowledge_in_access;
  logic [7:0]       status;

  // Firmware side feeds the output buffer
  assign fw_to_buf.data  = fw_out_data_i;
  assign fw_to_buf.valid = fw_out_valid_i;
  assign fw_out_ready_o  = fw_to_buf.ready;

  two_entry_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_out_buffer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .push      (fw_to_buf),
    .pop       (buf_to_host)
  );

  step_sync_ctrl u_step (
    .clk_i            (clk_i),
    .sys_rst_i        (sys_rst_i),
    .single_step_n_i  (single_step_n_i),
    .instr_boundary_i (instr_boundary_i),
    .run_o            (cpu_run_o),
    .halted_o         (halted),
    .sync_o           (sync_o)
  );

  // full while buffer holds a byte
  assign out_buffer_full               = buf_to_host.valid;
  assign buf_to_host.ready = data_read_done;

  // acknowledge acts as a data-buffer select
  assign dma_acknowledge_in_active = port2_special_en_i && !port2_i[P2_DMA_ACKNOWLEDGE_IN];
  assign selected    = !chip_select_n_i || dma_acknowledge_in_active;
  assign eff_rs      = dma_acknowledge_in_active ? 1'b0 : register_select_i;
  assign rd_act      = selected && !read_n_i;
  assign wr_act      = selected && !write_n_i;

  always_comb begin
    status                             = BYTE_RST;
    status[ST_OBF]                     = out_buffer_full;
    status[ST_IBF]                     = in_buffer_full;
    status[ST_FLAG0]                   = fw_flag0_i;
    status[ST_CMD]                     = in_cmd;
    status[ST_USER_LO +: USER_W]       = fw_status_user_i;
  end

  // Host strobe sequencing and data bus drive
  always_comb begin
    next_state     = state;
    next_read_sel  = read_sel;
    next_bus_out   = bus_out;
    next_bus_oe_n  = bus_oe_n;
    host_write     = 1'b0;
    data_read_done = 1'b0;
    dma_acknowledge_in_access    = 1'b0;
    unique case (state)
      H_IDLE: begin
        if (rd_act) begin
          next_state    = H_READ;
          next_read_sel = eff_rs;
          dma_acknowledge_in_access   = dma_acknowledge_in_active;
          next_bus_out  = eff_rs ? status : buf_to_host.data;
          next_bus_oe_n = 1'b0;
        end else if (wr_act) begin
          next_state  = H_WRITE;
          host_write  = 1'b1;
          dma_acknowledge_in_access = dma_acknowledge_in_active;
        end
      end
      H_READ: begin
        if (!rd_act) begin
          next_state     = H_IDLE;
          next_bus_oe_n  = 1'b1;
          data_read_done = !read_sel && out_buffer_full;
        end
      end
      H_WRITE: begin
        if (!wr_act) begin
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state    = H_IDLE;
        next_bus_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state    <= H_IDLE;
      read_sel <= 1'b0;
      bus_out  <= BYTE_RST;
      bus_oe_n <= 1'b1;
    end else begin
      state    <= next_state;
      read_sel <= next_read_sel;
      bus_out  <= next_bus_out;
      bus_oe_n <= next_bus_oe_n;
    end
  end

  // Input buffer
  always_comb begin
    next_in_data = in_data;
    next_in_cmd  = in_cmd;
    next_ibf     = in_buffer_full;
    if (fw_in_ready_i && in_buffer_full) begin
      next_ibf = 1'b0;
    end
    // A host write in the same cycle keeps the flag set
    if (host_write) begin
      next_in_data = host_data_bus_i;
      next_in_cmd  = eff_rs;
      next_ibf     = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_data <= BYTE_RST;
      in_cmd  <= 1'b0;
      in_buffer_full     <= 1'b0;
    end else begin
      in_data <= next_in_data;
      in_cmd  <= next_in_cmd;
      in_buffer_full     <= next_ibf;
    end
  end

  // DMA request
  always_comb begin
    next_drq = dma_request_out;
    if (dma_acknowledge_in_access) begin
      next_drq = 1'b0;
    end
    if (fw_dma_request_i) begin
      next_drq = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dma_request_out <= 1'b0;
    end else begin
      dma_request_out <= next_drq;
    end
  end

  // Port 1 pins: ordinary use or fetch address while halted
  always_comb begin
    next_p1_out  = port1_latch_i;
    next_p1_oe_n = ~port1_drive_i;
    if (halted) begin
      // low fetch address on port 1
      next_p1_out  = fetch_addr_i[FETCH_LO_W-1:0];
      next_p1_oe_n = BYTE_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p1_out  <= BYTE_RST;
      p1_oe_n <= OE_N_IDLE;
    end else begin
      p1_out  <= next_p1_out;
      p1_oe_n <= next_p1_oe_n;
    end
  end

  // Port 2 pins: ordinary, handshake or fetch address use
  always_comb begin
    next_p2_out  = port2_latch_i;
    next_p2_oe_n = ~port2_drive_i;
    if (port2_special_en_i) begin
      next_p2_out[P2_OBF]  = out_buffer_full;
      next_p2_oe_n[P2_OBF] = 1'b0;
      next_p2_out[P2_IBF]  = in_buffer_full;
      next_p2_oe_n[P2_IBF] = 1'b0;
      next_p2_out[P2_DRQ]   = dma_request_out;
      next_p2_oe_n[P2_DRQ]  = 1'b0;
      next_p2_out[P2_DMA_ACKNOWLEDGE_IN]  = 1'b1;
      next_p2_oe_n[P2_DMA_ACKNOWLEDGE_IN] = 1'b1;
    end
    if (halted) begin
      // high fetch address on port 2
      next_p2_out[P2_ADDR_LO +: FETCH_HI_W]  = fetch_addr_i[FETCH_W-1:FETCH_LO_W];
      next_p2_oe_n[P2_ADDR_LO +: FETCH_HI_W] = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p2_out  <= BYTE_RST;
      p2_oe_n <= OE_N_IDLE;
    end else begin
      p2_out  <= next_p2_out;
      p2_oe_n <= next_p2_oe_n;
    end
  end

  assign host_data_bus_o      = bus_out;
  assign host_data_bus_oe_n_o = bus_oe_n;
  assign fw_in_data_o         = in_data;
  assign fw_in_command_o      = in_cmd;
  assign fw_in_valid_o        = in_buffer_full;
  assign dma_request_out_o    = dma_request_out;
  assign port1_o              = p1_out;
  assign port1_oe_n_o         = p1_oe_n;
  assign port2_o              = p2_out;
  assign port2_oe_n_o         = p2_oe_n;

endmodule : slave_mcu_host_buffer_port

/* verif/host_port_assertions.sv */
// Purpose: Port-level checks for the host buffer port.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module from the testbench file.
`timescale 1ns/1ns
module host_port_assertions
  import host_port_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        chip_select_n_i,
  input wire logic        read_n_i,
  input wire logic        write_n_i,
  input wire logic        register_select_i,
  input wire logic [7:0]  host_data_bus_i,
  input wire logic [7:0]  host_data_bus_o,
  input wire logic        host_data_bus_oe_n_o,
  input wire logic [7:0]  fw_in_data_o,
  input wire logic        fw_in_command_o,
  input wire logic        fw_in_valid_o,
  input wire logic        fw_flag0_i,
  input wire logic [3:0]  fw_status_user_i,
  input wire logic        fw_dma_request_i,
  input wire logic        port2_special_en_i,
  input wire logic [7:0]  port1_o,
  input wire logic [7:0]  port2_o,
  input wire logic        dma_request_out_o,
  input wire logic        single_step_n_i,
  input wire logic        instr_boundary_i,
  input wire logic [10:0] fetch_addr_i,
  input wire logic        cpu_run_o,
  input wire logic        sync_o
);
  logic [10:0] fetch_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge clk_i) begin
    fetch_q <= fetch_addr_i;
  end
  sequence s_rd_take;
    $fell(read_n_i) && !chip_select_n_i && write_n_i && host_data_bus_oe_n_o;
  endsequence
  sequence s_wr_take;
    $fell(write_n_i) && !chip_select_n_i && read_n_i;
  endsequence
  sequence s_halt3;
    !cpu_run_o [*3];
  endsequence
  AST_RD_DRIVE: assert property (s_rd_take |=> !host_data_bus_oe_n_o)
    else $error("read not driven");
  AST_BUS_RELEASE: assert property (!host_data_bus_oe_n_o |-> $past(!read_n_i))
    else $error("bus driven outside read");
  AST_STATUS_BYTE: assert property (s_rd_take ##0 register_select_i |=>
    host_data_bus_o[7:4] == $past(fw_status_user_i) && host_data_bus_o[ST_FLAG0] == $past(fw_flag0_i)
    && host_data_bus_o[ST_IBF] == $past(fw_in_valid_o))
    else $error("status byte wrong");
  AST_WR_CAPTURE: assert property (s_wr_take |=> fw_in_valid_o
    && fw_in_data_o == $past(host_data_bus_i) && fw_in_command_o == $past(register_select_i))
    else $error("write not captured");
  AST_NO_SEL_WR: assert property (chip_select_n_i && !port2_special_en_i && !fw_in_valid_o |=>
    !fw_in_valid_o)
    else $error("write without select");
  AST_NO_SEL_RD: assert property (chip_select_n_i && $past(chip_select_n_i) && !port2_special_en_i
    |=> host_data_bus_oe_n_o)
    else $error("drive without select");
  AST_P2_INFULL: assert property (port2_special_en_i && $past(port2_special_en_i)
    && $stable(fw_in_valid_o) |-> port2_o[P2_IBF] == fw_in_valid_o)
    else $error("port2 input-full pin wrong");
  AST_DMA_SET: assert property (fw_dma_request_i |=> dma_request_out_o)
    else $error("dma request not set");
  AST_P2_DMA: assert property (port2_special_en_i && $past(port2_special_en_i)
    && $stable(dma_request_out_o) |-> port2_o[P2_DRQ] == dma_request_out_o)
    else $error("port2 dma pin wrong");
  AST_HALT: assert property (instr_boundary_i && !single_step_n_i && cpu_run_o |=>
    !cpu_run_o && !sync_o)
    else $error("no halt on step");
  AST_SYNC_RUN: assert property (instr_boundary_i && single_step_n_i && cpu_run_o |=> sync_o)
    else $error("no sync pulse");
  AST_RESUME: assert property (!cpu_run_o && single_step_n_i |=> cpu_run_o && sync_o)
    else $error("no resume");
  AST_FETCH_OUT: assert property (s_halt3 |-> port1_o == fetch_q[7:0]
    && port2_o[2:0] == fetch_q[10:8])
    else $error("fetch address not shown");
endmodule : host_port_assertions

/* verif/host_master_model.sv */
// Purpose: Host processor model on the parallel slave bus.
// Assumes: Host signals change 1 ns after a rising edge.
// Notes:   A released bus shows the inverse of its last value.
`timescale 1ns/1ns
module host_master_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_bus_i,
  input  wire logic       dev_oe_n_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            rs_o,
  output logic      [7:0] bus_o
);
  logic       drv = 1'b0;
  logic [7:0] hbyte = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    rs_o = 1'b0;
  end
  assign bus_o = !dev_oe_n_i ? dev_bus_i : (drv ? hbyte : ~last);
  always @(posedge clk_i) begin
    if (!dev_oe_n_i || drv) begin
      last <= bus_o;
    end
  end
  task automatic wr(input logic cs, input logic rs, input logic [7:0] d);
    @(posedge clk_i) #1;
    cs_n_o = cs;
    rs_o = rs;
    hbyte = d;
    drv = 1'b1;
    wr_n_o = 1'b0;
    @(posedge clk_i) #1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    drv = 1'b0;
    @(posedge clk_i) #1;
  endtask : wr
  task automatic rd(input logic cs, input logic rs, output logic [7:0] d);
    int n;
    @(posedge clk_i) #1;
    cs_n_o = cs;
    rs_o = rs;
    rd_n_o = 1'b0;
    d = 8'hxx;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_i);
      if (!dev_oe_n_i) begin
        d = bus_o;
        break;
      end
    end
    #1;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : rd
endmodule : host_master_model

/* verif/testbench.sv */
// Purpose: Self-checking bench for the host buffer port.
// Assumes: 25 MHz clock, inputs move 1 ns after the edge.
// Notes:   Host side is driven by the master model.
`timescale 1ns/1ns
module testbench;
  import host_port_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, rd_n, wr_n, rs, oe_n, in_cmd, in_valid, out_ready, req_out, run, sync;
  logic        out_valid = 1'b0, in_ready = 1'b0, dma_req = 1'b0, sp_en = 1'b0;
  logic        ss_n = 1'b1, bnd = 1'b0, ack_n = 1'b1;
  logic [7:0]  bus_in, bus_out, in_data, p1, p1_oe_n, p2, p2_oe_n, rd_byte;
  logic [7:0]  out_data = 8'h00, p2_latch = 8'h00, p2_drive = 8'h00;
  logic [10:0] fetch = 11'h000;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  slave_mcu_host_buffer_port uut (
    .host_data_bus_i(bus_in), .clk_i(clk), .sys_rst_i(rst), .chip_select_n_i(cs_n),
    .read_n_i(rd_n), .write_n_i(wr_n), .register_select_i(rs), .host_data_bus_o(bus_out),
    .host_data_bus_oe_n_o(oe_n), .fw_out_data_i(out_data), .fw_out_valid_i(out_valid),
    .fw_out_ready_o(out_ready), .fw_in_data_o(in_data), .fw_in_command_o(in_cmd),
    .fw_in_valid_o(in_valid), .fw_in_ready_i(in_ready), .fw_flag0_i(1'b1),
    .fw_status_user_i(4'hC), .fw_dma_request_i(dma_req), .port2_special_en_i(sp_en),
    .port1_latch_i(8'h00), .port1_drive_i(8'h00), .port2_latch_i(p2_latch),
    .port2_drive_i(p2_drive), .port2_i({ack_n, 7'h7F}), .port1_o(p1), .port1_oe_n_o(p1_oe_n),
    .port2_o(p2), .port2_oe_n_o(p2_oe_n), .dma_request_out_o(req_out),
    .single_step_n_i(ss_n), .instr_boundary_i(bnd), .fetch_addr_i(fetch), .cpu_run_o(run),
    .sync_o(sync));
  host_master_model host (.clk_i(clk), .dev_bus_i(bus_out), .dev_oe_n_i(oe_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .rs_o(rs), .bus_o(bus_in));
  task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic push(input logic [7:0] d);
    @(posedge clk) #1;
    out_data = d;
    out_valid = 1'b1;
    repeat (8) begin
      @(posedge clk);
      if (out_ready) break;
    end
    #1;
    out_valid = 1'b0;
  endtask : push
  task automatic clk1;
    @(posedge clk) #1;
  endtask : clk1
  task automatic t_reset;
    check("bus_oe_n", 1'b1, oe_n);
    check("p2_oe_n", 8'hFF, p2_oe_n);
    check("out_ready", 1'b1, out_ready);
    check("run", 1'b1, run);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_write;
    host.wr(1'b0, 1'b0, 8'h5A);
    check("in_data", 8'h5A, in_data);
    check("in_cmd", 1'b0, in_cmd);
    host.rd(1'b0, 1'b1, rd_byte);
    check("status", 8'hC6, rd_byte);
    host.wr(1'b0, 1'b1, 8'hA5);
    check("in_data", 8'hA5, in_data);
    check("in_cmd", 1'b1, in_cmd);
    in_ready = 1'b1;
    clk1();
    in_ready = 1'b0;
    clk1();
    check("in_valid", 1'b0, in_valid);
    host.rd(1'b0, 1'b1, rd_byte);
    check("status", 8'hCC, rd_byte);
    $display("t_write done");
  endtask : t_write
  task automatic t_stray;
    host.wr(1'b1, 1'b0, 8'h33);
    check("in_valid", 1'b0, in_valid);
    host.rd(1'b1, 1'b0, rd_byte);
    check("stray_rd", 8'hxx, rd_byte);
    $display("t_stray done");
  endtask : t_stray
  task automatic t_out;
    sp_en = 1'b1;
    push(8'h11);
    push(8'h22);
    clk1();
    check("out_ready", 1'b0, out_ready);
    clk1();
    check("p2_out_full", 1'b1, p2[P2_OBF]);
    host.rd(1'b0, 1'b1, rd_byte);
    check("status", 8'hCD, rd_byte);
    host.rd(1'b0, 1'b0, rd_byte);
    check("data", 8'h11, rd_byte);
    check("out_ready", 1'b1, out_ready);
    host.rd(1'b0, 1'b0, rd_byte);
    check("data", 8'h22, rd_byte);
    host.rd(1'b0, 1'b1, rd_byte);
    check("status", 8'hCC, rd_byte);
    check("p2_out_full", 1'b0, p2[P2_OBF]);
    $display("t_out done");
  endtask : t_out
  task automatic t_dma;
    push(8'h3C);
    dma_req = 1'b1;
    clk1();
    dma_req = 1'b0;
    check("req_out", 1'b1, req_out);
    clk1();
    clk1();
    check("p2_req", 1'b1, p2[P2_DRQ]);
    ack_n = 1'b0;
    host.rd(1'b1, 1'b1, rd_byte);
    ack_n = 1'b1;
    check("ack_data", 8'h3C, rd_byte);
    check("req_out", 1'b0, req_out);
    dma_req = 1'b1;
    clk1();
    dma_req = 1'b0;
    ack_n = 1'b0;
    check("req_out", 1'b1, req_out);
    host.wr(1'b1, 1'b1, 8'h77);
    ack_n = 1'b1;
    check("ack_wr_data", 8'h77, in_data);
    check("ack_wr_cmd", 1'b0, in_cmd);
    check("req_out", 1'b0, req_out);
    sp_en = 1'b0;
    $display("t_dma done");
  endtask : t_dma
  task automatic t_ports;
    p2_latch = 8'h96;
    p2_drive = 8'hFF;
    clk1();
    clk1();
    check("p2", 8'h96, p2);
    check("p2_oe_n", 8'h00, p2_oe_n);
    $display("t_ports done");
  endtask : t_ports
  task automatic t_step;
    fetch = 11'h5A3;
    ss_n = 1'b0;
    bnd = 1'b1;
    clk1();
    bnd = 1'b0;
    check("run", 1'b0, run);
    check("sync", 1'b0, sync);
    repeat (3) clk1();
    check("p1", 8'hA3, p1);
    check("p2_lo", 3'h5, p2[2:0]);
    check("p1_oe_n", 8'h00, p1_oe_n);
    ss_n = 1'b1;
    clk1();
    check("run", 1'b1, run);
    check("sync", 1'b1, sync);
    bnd = 1'b1;
    clk1();
    bnd = 1'b0;
    check("sync", 1'b1, sync);
    clk1();
    check("sync", 1'b0, sync);
    check("p1", 8'h00, p1);
    check("p1_oe_n", 8'hFF, p1_oe_n);
    $display("t_step done");
  endtask : t_step
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_write();
    t_stray();
    t_out();
    t_dma();
    t_ports();
    t_step();
    test_done();
  end
endmodule : testbench
bind slave_mcu_host_buffer_port host_port_assertions u_chk (.clk_i, .sys_rst_i, .chip_select_n_i,
  .read_n_i, .write_n_i, .register_select_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_n_o,
  .fw_in_data_o, .fw_in_command_o, .fw_in_valid_o, .fw_flag0_i, .fw_status_user_i, .fw_dma_request_i,
  .port2_special_en_i, .port1_o, .port2_o, .dma_request_out_o, .single_step_n_i, .instr_boundary_i,
  .fetch_addr_i, .cpu_run_o, .sync_o);
